// ### hdl/tvrl_top.sv
// Timer value read-out: counter, snapshot latch and AHB-Lite register file.
// Assumes a 10 MHz sys_clk, synchronous active-low resetn and word-only bus reads.
`timescale 1ns/100ps
`default_nettype none
`include "tvrl_map.svh"

// Function
// - Present 32-bit timer value to software through two read-only 16-bit registers.
// - Reading the lower register captures the whole count; upper reads return it.
// - Both timer read registers hold zero after reset.
// - Timer bits 31 to 16 are read-only at the upper register.
// - The timer increments only while its count enable is one.
// - Clearing the count enable stops the timer and clears it to zero.
module tvrl_top #(
	parameter int COUNT_W = 32
) (
	input  wire logic               sys_clk,
	input  wire logic               resetn,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic               hready,
	input  wire logic [31:0]        hwdata,
	output logic      [31:0]        hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	output logic      [COUNT_W-1:0] timer_count,
	output logic                    count_en
);

	localparam int HALF = `TVRL_HALF_W;

	// ------------------------------------------------------------------------
	// Address decoding
	// ------------------------------------------------------------------------
	// A register index sits at four times its value on the byte-addressed bus.
	function automatic logic hit(input logic [31:0] addr, input tvrl_pkg::tvrl_idx_t idx);
		hit = (addr == {20'h0_0000, idx, 2'h0});
	endfunction : hit

	logic        rd_take;
	logic [31:0] rd_addr;
	logic [31:0] rd_value;
	logic        wr_en;
	logic [31:0] wr_addr;
	logic [31:0] wr_data;

	logic [COUNT_W-1:0] snap_q;
	logic [COUNT_W-1:0] snap_d;
	logic               en_q;
	logic               en_d;
	logic               zero_q;
	logic               zero_d;
	logic               order_q;
	logic               order_d;
	tvrl_pkg::tvrl_seq_t seq_q;
	tvrl_pkg::tvrl_seq_t seq_d;

	logic rd_low;
	logic rd_high;
	logic rd_ctrl;
	logic rd_stat;
	logic wr_ctrl;
	logic wr_stat;

	// ------------------------------------------------------------------------
	// Bus front end
	// ------------------------------------------------------------------------
	tvrl_ahb_slave u_bus (
		.sys_clk   (sys_clk),
		.resetn    (resetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hready    (hready),
		.hwdata    (hwdata),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.rd_take   (rd_take),
		.rd_addr   (rd_addr),
		.rd_value  (rd_value),
		.wr_en     (wr_en),
		.wr_addr   (wr_addr),
		.wr_data   (wr_data)
	);

	// ------------------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------------------
	tvrl_timer #(
		.WIDTH (COUNT_W)
	) u_timer (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.count_en (en_q),
		.count_q  (timer_count)
	);

	// ------------------------------------------------------------------------
	// Access decode
	// ------------------------------------------------------------------------
	// Only word transfers are supported; hsize is not checked.
	always_comb begin
		rd_low  = rd_take && hit(rd_addr, `TVRL_IDX_SNAP_LOW);
		rd_high = rd_take && hit(rd_addr, `TVRL_IDX_SNAP_HIGH);
		rd_ctrl = rd_take && hit(rd_addr, `TVRL_IDX_CTRL);
		rd_stat = rd_take && hit(rd_addr, `TVRL_IDX_STATUS);
		wr_ctrl = wr_en && hit(wr_addr, `TVRL_IDX_CTRL);
		wr_stat = wr_en && hit(wr_addr, `TVRL_IDX_STATUS);
	end

	// ------------------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------------------
	// The lower register shows the live count, which is exactly what is latched.
	always_comb begin
		rd_value = 32'h0000_0000;
		if (rd_low) begin
			rd_value[HALF-1:0] = timer_count[HALF-1:0];
		end else if (rd_high) begin
			rd_value[HALF-1:0] = snap_q[COUNT_W-1:HALF];
		end else if (rd_ctrl) begin
			rd_value[`TVRL_CTRL_EN_BIT] = en_q;
		end else if (rd_stat) begin
			rd_value[`TVRL_STAT_HELD_BIT]  = (seq_q == tvrl_pkg::TVRL_SEQ_HELD);
			rd_value[`TVRL_STAT_ZERO_BIT]  = zero_q;
			rd_value[`TVRL_STAT_ORDER_BIT] = order_q;
		end
	end

	// ------------------------------------------------------------------------
	// Snapshot latch and read sequence
	// ------------------------------------------------------------------------
	// A read of the upper register without a prior lower read sets the order flag.
	// The zero flag tells software that a retry of the sequence is due.
	always_comb begin
		snap_d  = snap_q;
		seq_d   = seq_q;
		zero_d  = zero_q;
		order_d = order_q;
		if (wr_stat && wr_data[`TVRL_STAT_ORDER_BIT]) begin
			order_d = 1'h0;
		end
		if (rd_low) begin
			snap_d = timer_count;
			seq_d  = tvrl_pkg::TVRL_SEQ_HELD;
			zero_d = (timer_count[7:0] == 8'h00);
		end else if (rd_high) begin
			if (seq_q == tvrl_pkg::TVRL_SEQ_IDLE) begin
				order_d = 1'h1;
			end
			seq_d = tvrl_pkg::TVRL_SEQ_IDLE;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			snap_q  <= COUNT_W'(`TVRL_SNAP_RST);
			seq_q   <= tvrl_pkg::TVRL_SEQ_IDLE;
			zero_q  <= 1'h0;
			order_q <= 1'h0;
		end else begin
			snap_q  <= snap_d;
			seq_q   <= seq_d;
			zero_q  <= zero_d;
			order_q <= order_d;
		end
	end

	// ------------------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------------------
	always_comb begin
		en_d = en_q;
		if (wr_ctrl) begin
			en_d = wr_data[`TVRL_CTRL_EN_BIT];
		end
		count_en = en_q;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			en_q <= `TVRL_CTRL_EN_RST;
		end else begin
			en_q <= en_d;
		end
	end

endmodule : tvrl_top
`default_nettype wire

// ### hdl/tvrl_map.svh
// Register map, field positions, reset values and AHB codes of the timer read-out.
// Assumes a 32-bit AHB-Lite data bus; each register index maps to a word at four times it.
`ifndef TVRL_MAP_SVH
`define TVRL_MAP_SVH

// ----------------------------------------------------------------------------
// Register indexes
// ----------------------------------------------------------------------------
`define TVRL_IDX_SNAP_LOW   10'h020
`define TVRL_IDX_SNAP_HIGH  10'h022
`define TVRL_IDX_CTRL       10'h034
`define TVRL_IDX_STATUS     10'h035

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TVRL_CTRL_EN_BIT    0
`define TVRL_STAT_HELD_BIT  0
`define TVRL_STAT_ZERO_BIT  1
`define TVRL_STAT_ORDER_BIT 2
`define TVRL_HALF_W         16

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define TVRL_SNAP_RST       32'h0000_0000
`define TVRL_COUNT_RST      32'h0000_0000
`define TVRL_CTRL_EN_RST    1'h0
`define TVRL_RDATA_RST      32'h0000_0000

// ----------------------------------------------------------------------------
// AHB-Lite codes
// ----------------------------------------------------------------------------
`define TVRL_HTRANS_NSEQ_BIT 1
`define TVRL_HRESP_OKAY     1'h0

`endif

// ### hdl/tvrl_pkg.sv
// Types shared by the timer read-out files.
// Assumes tvrl_map.svh carries all numeric constants.
package tvrl_pkg;

	// Read sequence: idle, or a snapshot held for the upper half.
	typedef enum logic [0:0] {
		TVRL_SEQ_IDLE = 1'h0,
		TVRL_SEQ_HELD = 1'h1
	} tvrl_seq_t;

	typedef logic [9:0] tvrl_idx_t;

endpackage : tvrl_pkg

// ### hdl/tvrl_timer.sv
// Enable-gated up counter of the timer read-out; clears to zero while disabled.
// Assumes one clock, synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
`include "tvrl_map.svh"

module tvrl_timer #(
	parameter int WIDTH = 32
) (
	input  wire logic             sys_clk,
	input  wire logic             resetn,
	input  wire logic             count_en,
	output logic      [WIDTH-1:0] count_q
);

	logic [WIDTH-1:0] count_d;

	// ------------------------------------------------------------------------
	// Count
	// ------------------------------------------------------------------------
	always_comb begin
		if (count_en) begin
			count_d = count_q + WIDTH'(1);
		end else begin
			count_d = '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			count_q <= WIDTH'(`TVRL_COUNT_RST);
		end else begin
			count_q <= count_d;
		end
	end

endmodule : tvrl_timer
`default_nettype wire

// ### hdl/tvrl_ahb_slave.sv
// AHB-Lite slave front end: takes transfers, returns registered read data.
// Assumes single word transfers and a single slave whose hreadyout is hready.
`timescale 1ns/100ps
`default_nettype none
`include "tvrl_map.svh"

module tvrl_ahb_slave (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             rd_take,
	output logic      [31:0] rd_addr,
	input  wire logic [31:0] rd_value,
	output logic             wr_en,
	output logic      [31:0] wr_addr,
	output logic      [31:0] wr_data
);

	logic        take;
	logic        wr_pend_q;
	logic        wr_pend_d;
	logic [31:0] wr_addr_q;
	logic [31:0] wr_addr_d;
	logic [31:0] hrdata_q;
	logic [31:0] hrdata_d;

	// ------------------------------------------------------------------------
	// Address phase
	// ------------------------------------------------------------------------
	always_comb begin
		take      = hsel && htrans[`TVRL_HTRANS_NSEQ_BIT] && hready;
		rd_take   = take && !hwrite;
		rd_addr   = haddr;
		wr_pend_d = take && hwrite;
		wr_addr_d = (take && hwrite) ? haddr : wr_addr_q;
		hrdata_d  = rd_take ? rd_value : hrdata_q;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			wr_pend_q <= 1'h0;
			wr_addr_q <= 32'h0000_0000;
			hrdata_q  <= `TVRL_RDATA_RST;
		end else begin
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
			hrdata_q  <= hrdata_d;
		end
	end

	// ------------------------------------------------------------------------
	// Data phase
	// ------------------------------------------------------------------------
	// The slave never waits, so a write completes in its first data cycle.
	always_comb begin
		wr_en     = wr_pend_q;
		wr_addr   = wr_addr_q;
		wr_data   = hwdata;
		hrdata    = hrdata_q;
		hreadyout = 1'h1;
		hresp     = `TVRL_HRESP_OKAY;
	end

endmodule : tvrl_ahb_slave
`default_nettype wire

// ### dv/tvrl_top_props.sv
// Checker of the timer read-out ports.
// Assumes single-slave AHB-Lite with zero wait states.
`timescale 1ns/100ps
`default_nettype none
`include "tvrl_map.svh"

module tvrl_top_props #(
	parameter int COUNT_W = 32
) (
	input wire logic               sys_clk,
	input wire logic               resetn,
	input wire logic               hsel,
	input wire logic [31:0]        haddr,
	input wire logic [1:0]         htrans,
	input wire logic               hwrite,
	input wire logic [31:0]        hwdata,
	input wire logic               hready,
	input wire logic [31:0]        hrdata,
	input wire logic               hreadyout,
	input wire logic               hresp,
	input wire logic [COUNT_W-1:0] timer_count,
	input wire logic               count_en
);
	localparam logic [31:0] A_LOW = {20'h0, `TVRL_IDX_SNAP_LOW, 2'h0};
	localparam logic [31:0] A_HIGH = {20'h0, `TVRL_IDX_SNAP_HIGH, 2'h0};
	localparam logic [31:0] A_CTRL = {20'h0, `TVRL_IDX_CTRL, 2'h0};
	localparam logic [31:0] A_STAT = {20'h0, `TVRL_IDX_STATUS, 2'h0};
	logic               take;
	logic               rd;
	logic [COUNT_W-1:0] snap_d;
	logic [COUNT_W-1:0] snap_q;
	assign take = hsel & htrans[1] & hready;
	assign rd = take & !hwrite;

	// Shadow of the count latched by the last low read.
	always_comb begin
		snap_d = snap_q;
		if (!resetn)
			snap_d = '0;
		else if (rd && haddr == A_LOW)
			snap_d = timer_count;
	end
	always_ff @(posedge sys_clk) begin
		snap_q <= snap_d;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	bus_always_ok_a: assert property (hreadyout && !hresp)
		else $error("bus not ready or error response");
	count_step_a: assert property (count_en |=> timer_count == $past(timer_count) + 1'b1)
		else $error("timer did not step by one");
	count_clear_a: assert property (!count_en |=> timer_count == '0)
		else $error("stopped timer not zero");
	low_read_a: assert property (rd && haddr == A_LOW |=>
		hrdata == {16'h0, $past(timer_count[15:0])})
		else $error("low read value wrong");
	high_read_a: assert property (rd && haddr == A_HIGH |=>
		hrdata == {16'h0, $past(snap_q[31:16])})
		else $error("high read not from latch");
	unmapped_read_a: assert property (rd && haddr != A_LOW && haddr != A_HIGH
		&& haddr != A_CTRL && haddr != A_STAT |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	enable_write_a: assert property (take && hwrite && haddr == A_CTRL |=>
		##1 count_en == $past(hwdata[0]))
		else $error("count enable not written");
	idle_hold_a: assert property (!rd |=> $stable(hrdata))
		else $error("read data changed without a read");
endmodule : tvrl_top_props

bind tvrl_top tvrl_top_props #(.COUNT_W(COUNT_W)) props_u (.sys_clk(sys_clk),
	.resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .timer_count(timer_count), .count_en(count_en));
`default_nettype wire

// ### dv/tvrl_top_tb.sv
// Self-checking bench of the timer read-out.
// Assumes the checker is bound in; drives the AHB-Lite master side.
`timescale 1ns/100ps
`default_nettype none
`include "tvrl_map.svh"

module tvrl_top_tb;
	localparam logic [31:0] A_LOW = {20'h0, `TVRL_IDX_SNAP_LOW, 2'h0};
	localparam logic [31:0] A_HIGH = {20'h0, `TVRL_IDX_SNAP_HIGH, 2'h0};
	localparam logic [31:0] A_CTRL = {20'h0, `TVRL_IDX_CTRL, 2'h0};
	localparam logic [31:0] A_STAT = {20'h0, `TVRL_IDX_STATUS, 2'h0};
	logic        sys_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] d;
	wire  [31:0] hrdata;
	wire         hreadyout;
	wire         hresp;
	wire  [31:0] timer_count;
	wire         count_en;
	int          bad_count = 0;
	int          n_compared = 0;
	int          cyc = 0;

	tvrl_top #(.COUNT_W(32)) dut_u (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .timer_count(timer_count), .count_en(count_en));

	initial begin
		forever #50 sys_clk = ~sys_clk;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One single transfer; called at a rising edge, returns at the data edge.
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		htrans <= 2'h2;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask : xfer

	task sc_reset_order;
		xfer(1'b0, A_HIGH, 32'h0, d); chk(d, 32'h0);
		xfer(1'b0, A_STAT, 32'h0, d); chk(d & 32'h4, 32'h4);
		xfer(1'b1, A_STAT, 32'h4, d);
		xfer(1'b0, A_LOW, 32'h0, d); chk(d, 32'h0);
		xfer(1'b0, A_STAT, 32'h0, d); chk(d & 32'h7, 32'h3);
		xfer(1'b0, 32'h0000_0084, 32'h0, d); chk(d, 32'h0);
	endtask : sc_reset_order

	task sc_count;
		xfer(1'b1, A_CTRL, 32'h1, d);
		xfer(1'b0, A_LOW, 32'h0, d); chk(d, 32'h0);
		xfer(1'b0, A_LOW, 32'h0, d); chk(d, 32'h2);
		chk({31'h0, count_en}, 32'h1);
		xfer(1'b1, A_CTRL, 32'h0, d);
		xfer(1'b0, A_CTRL, 32'h0, d); chk(d, 32'h0);
		chk(timer_count, 32'h0);
		xfer(1'b0, A_LOW, 32'h0, d); chk(d, 32'h0);
		xfer(1'b0, A_HIGH, 32'h0, d); chk(d, 32'h0);
	endtask : sc_count

	// Low read just below the half carry; the high read after the carry must stay old.
	task sc_latch;
		xfer(1'b1, A_CTRL, 32'h1, d);
		repeat (65528) @(posedge sys_clk);
		xfer(1'b0, A_LOW, 32'h0, d); chk(d, 32'h0000_FFF8);
		chk(timer_count, 32'h0000_FFF9);
		repeat (20) @(posedge sys_clk);
		xfer(1'b0, A_HIGH, 32'h0, d); chk(d, 32'h0);
		xfer(1'b0, A_LOW, 32'h0, d); chk(d, 32'h0010);
		xfer(1'b0, A_HIGH, 32'h0, d); chk(d, 32'h1);
	endtask : sc_latch

	// Low read with a zero low byte, then the retry well within 256 counts.
	task sc_retry;
		xfer(1'b1, A_CTRL, 32'h0, d);
		xfer(1'b1, A_CTRL, 32'h1, d);
		repeat (256) @(posedge sys_clk);
		xfer(1'b0, A_LOW, 32'h0, d); chk(d, 32'h0000_0100);
		xfer(1'b0, A_STAT, 32'h0, d); chk(d & 32'h3, 32'h3);
		xfer(1'b0, A_LOW, 32'h0, d); chk(d, 32'h0000_0104);
		xfer(1'b0, A_STAT, 32'h0, d); chk(d & 32'h3, 32'h1);
		xfer(1'b0, A_HIGH, 32'h0, d); chk(d, 32'h0);
	endtask : sc_retry

	task tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 80000) begin
			bad_count++;
			tally_and_finish();
		end
	end

	initial begin
		repeat (5) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		sc_reset_order();
		sc_count();
		sc_latch();
		sc_retry();
		tally_and_finish();
	end
endmodule : tvrl_top_tb
`default_nettype wire
